// File: design/msc_consts.svh
`ifndef MSC_CONSTS_SVH
`define MSC_CONSTS_SVH
// Behaviour
// - Display point values span -19999 to 99999
// - Input point values span 0 to 29999
// - Measured style stores the live reading
// - Outside points, extend along the line
// - Zero function offsets reading to zero
// - Reset function loads assigned values
// - Hold freezes assigned display while active
// - Advance display, step brightness, toggle colour
// - Print request, then momentary reset
// - Setpoint codes reset output one, two, both
// - Assignment used only by reset, hold, print-reset
// - Max captured after display above for delay
// - Min captured after display below for delay
// - Code 66 restores defaults, shows indication
// - Code 50 shows version, returns to prompt
// - Code 48 plus two-second select starts calibration
// - Zero step about eight seconds, then full scale
// - Scroll every four seconds, needs min/max
// - Zero on reset only when input shown
// - Brightness levels one to five, immediate
// - Zeroing updates the stored offset

// ==========================================
// Register byte offsets
`define MSC_A_CTRL   8'h00
`define MSC_A_DP1    8'h04
`define MSC_A_IP1    8'h08
`define MSC_A_DP2    8'h0c
`define MSC_A_IP2    8'h10
`define MSC_A_OFFSET 8'h14
`define MSC_A_DELAY  8'h18
`define MSC_A_CMD    8'h1c
`define MSC_A_SVC    8'h20
`define MSC_A_VALUE  8'h24
`define MSC_A_MAX    8'h28
`define MSC_A_MIN    8'h2c
`define MSC_A_LIVE   8'h30

// ==========================================
// Control field positions
`define MSC_F_STYLE  0
`define MSC_F_FUNC   1
`define MSC_F_ASG    5
`define MSC_F_MAXEN  8
`define MSC_F_MINEN  9
`define MSC_F_SCROLL 10
`define MSC_F_ZRST   11
`define MSC_F_SELEN  12
`define MSC_F_RSTEN  13
`define MSC_F_COLOR  14
`define MSC_F_LEVEL  15
`define MSC_F_MINDLY 16

// ==========================================
// Reset values and limits
`define MSC_CTRL_RST 32'h0002b000
`define MSC_DP2_RST  18'h04e20
`define MSC_IP2_RST  15'h4e20
`define MSC_DISP_MIN 18'sh3b1e1
`define MSC_DISP_MAX 18'sh1869f
`define MSC_IN_MAX   15'h752f
`define MSC_DLY_MAX  14'h270f
`define MSC_LVL_MIN  3'h1
`define MSC_LVL_MAX  3'h5
`define MSC_RANGE_EXIT 3'h4
`define MSC_VERSION  8'h10

// ==========================================
// Service codes
`define MSC_SVC_RESTORE 8'h42
`define MSC_SVC_VERSION 8'h32
`define MSC_SVC_CAL     8'h30

// ==========================================
// Timing
`define MSC_CLK_HZ    40000000
`define MSC_TICK_S    1
`define MSC_SCROLL_S  4
`define MSC_CALHOLD_S 2
`define MSC_CALZERO_S 8
`define MSC_IND_S     2
`endif

// File: design/msc_pkg.sv
package msc_pkg;
	typedef enum logic [3:0] {
		UF_NONE, UF_LOCK, UF_ZERO, UF_RESET, UF_HOLD, UF_DSEL, UF_LEVEL,
		UF_COLOR, UF_PRINT, UF_PRST, UF_SP1, UF_SP2, UF_SPBOTH
	} msc_ufunc_e;
	typedef enum logic [2:0] {
		SV_PROMPT, SV_RESTORE, SV_VERSION, SV_ARMED,
		SV_CALSEL, SV_CALZERO, SV_CALRUN, SV_CALFULL
	} msc_svc_e;
	typedef logic signed [17:0] msc_disp_t;
endpackage

// File: design/msc_cap_if.sv
`timescale 1ns/100ps
interface msc_cap_if;
	msc_pkg::msc_disp_t disp;
	logic               en;
	logic [13:0]        dly;
	logic               tick;
	logic               load;
	msc_pkg::msc_disp_t val;
	modport core (output disp, output en, output dly, output tick, output load, input val);
	modport cap (input disp, input en, input dly, input tick, input load, output val);
endinterface

// File: design/msc_pin_sync.sv
`timescale 1ns/100ps
module msc_pin_sync #(
	parameter int W = 3
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise
);
	logic [W-1:0] meta;
	logic [W-1:0] prev;

	// ==========================================
	// Two flops before use; prev only sees the second
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta  <= '0;
			level <= '0;
			prev  <= '0;
		end else begin
			meta  <= pinIn;
			level <= meta;
			prev  <= level;
		end
	end

	// Active edge of each pin
	assign rise = level & ~prev;
endmodule

// File: design/msc_capture.sv
`timescale 1ns/100ps
`include "msc_consts.svh"
module msc_capture #(
	parameter bit IS_MAX = 1'b1
) (
	input wire logic clk,
	input wire logic sys_rst,
	msc_cap_if.cap   cif
);
	logic [13:0] secs;
	logic        beyond;

	// ==========================================
	// Direction of the capture test
	assign beyond = IS_MAX ? (cif.disp > cif.val) : (cif.disp < cif.val);

	// Short spikes restart the wait, so with a delay of two or more seconds a spike under one second never captures
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cif.val <= IS_MAX ? `MSC_DISP_MIN : `MSC_DISP_MAX;
			secs    <= 14'h0;
		end else if (cif.load) begin
			cif.val <= cif.disp;
			secs    <= 14'h0;
		end else if (!cif.en || !beyond) begin
			secs <= 14'h0;
		end else if (secs >= cif.dly) begin
			cif.val <= cif.disp;
			secs    <= 14'h0;
		end else if (cif.tick) begin
			secs <= secs + 14'h1;
		end
	end

	a_cap_cause:
	assert property (@(posedge clk) disable iff (sys_rst)
		($changed(cif.val) && !$past(cif.load)) |-> $past(cif.en && beyond
			&& secs >= cif.dly))
	else $error("capture taken without enable, excursion or delay");
endmodule

// File: design/msc_meter_core.sv
`timescale 1ns/100ps
`include "msc_consts.svh"
module msc_meter_core #(
	parameter int       SEC_CYCLES = `MSC_CLK_HZ * `MSC_TICK_S,
	parameter bit       BACKLIT    = 1'b1,
	parameter bit [7:0] VERSION    = `MSC_VERSION // Arbitrary value
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        selBtnPin,
	input  wire logic        rstBtnPin,
	input  wire logic        userPin,
	input  wire logic [14:0] rawIn,
	output logic      [17:0] dispOut,
	output logic      [1:0]  shownSel,
	output logic      [2:0]  intensity,
	output logic             colourGreen,
	output logic             printReq,
	output logic      [1:0]  spReset,
	output logic      [2:0]  calRange,
	output logic             calZero,
	output logic             calFull
);
	localparam int DW = $clog2(SEC_CYCLES);

	logic [31:0]          ctrl;
	msc_pkg::msc_disp_t   dp1;
	msc_pkg::msc_disp_t   dp2;
	msc_pkg::msc_disp_t   offset;
	msc_pkg::msc_disp_t   scaledQ;
	logic [14:0]          ip1;
	logic [14:0]          ip2;
	logic [13:0]          maxDly;
	logic [13:0]          minDly;
	logic [DW-1:0]        divCnt;
	logic                 secTick;
	logic [2:0]           scrollSecs;
	logic [3:0]           svcSecs;
	logic                 prstPend;
	msc_pkg::msc_svc_e    svc;
	msc_pkg::msc_svc_e    next_svc;
	logic [2:0]           lvl;
	logic [2:0]           rise;

	// ==========================================
	// Functions
	function automatic msc_pkg::msc_disp_t clampD(input logic signed [34:0] v);
		if (v < `MSC_DISP_MIN)
			return `MSC_DISP_MIN;
		if (v > `MSC_DISP_MAX)
			return `MSC_DISP_MAX;
		return v[17:0];
	endfunction

	function automatic logic [14:0] clampI(input logic [31:0] v);
		return (v > {17'h0, `MSC_IN_MAX}) ? `MSC_IN_MAX : v[14:0];
	endfunction

	function automatic logic [13:0] clampS(input logic [15:0] v);
		return (v > {2'h0, `MSC_DLY_MAX}) ? `MSC_DLY_MAX : v[13:0];
	endfunction

	function automatic logic [31:0] ext32(input msc_pkg::msc_disp_t d);
		return {{14{d[17]}}, d};
	endfunction

	// ==========================================
	// Pin synchronisers: sel, rst, user input
	msc_pin_sync #(
		.W(3)
	) u_sync (
		.clk    (clk),
		.sys_rst(sys_rst),
		.pinIn  ({userPin, rstBtnPin, selBtnPin}),
		.level  (lvl),
		.rise   (rise)
	);

	// ==========================================
	// Control field decode
	msc_pkg::msc_ufunc_e ufunc;
	wire  [2:0] asg      = ctrl[`MSC_F_ASG +: 3];
	wire        measured = ctrl[`MSC_F_STYLE];
	wire        maxEn    = ctrl[`MSC_F_MAXEN];
	wire        minEn    = ctrl[`MSC_F_MINEN];
	wire        zeroRst  = ctrl[`MSC_F_ZRST];
	wire  [2:0] curLevel = ctrl[`MSC_F_LEVEL +: 3];
	wire        scrollOn = ctrl[`MSC_F_SCROLL] & (maxEn | minEn);
	assign ufunc = msc_pkg::msc_ufunc_e'(ctrl[`MSC_F_FUNC +: 4]);

	// ==========================================
	// APB decode; one access cycle, no wait states
	wire        setupCyc = psel & ~penable;
	wire        apbWr    = psel & penable & pready & pwrite;
	wire        mapped   = (paddr <= `MSC_A_LIVE) && (paddr[1:0] == 2'h0);
	wire        wrCtrl   = apbWr && paddr == `MSC_A_CTRL;
	wire        wrOff    = apbWr && paddr == `MSC_A_OFFSET;
	wire        wrPts    = apbWr && (paddr >= `MSC_A_DP1) && (paddr <= `MSC_A_IP2);
	wire        wrDly    = apbWr && paddr == `MSC_A_DELAY;
	wire        wrCmd    = apbWr && paddr == `MSC_A_CMD;
	wire        svcWr    = apbWr && paddr == `MSC_A_SVC;
	wire [7:0]  svcCode  = pwdata[7:0];
	wire        restoreNow = svc == msc_pkg::SV_PROMPT && svcWr
		&& svcCode == `MSC_SVC_RESTORE;
	msc_pkg::msc_disp_t dispVal;
	msc_pkg::msc_disp_t maxQ;
	msc_pkg::msc_disp_t minQ;
	wire [31:0] rdMux =
		(paddr == `MSC_A_CTRL)   ? ctrl :
		(paddr == `MSC_A_DP1)    ? ext32(dp1) :
		(paddr == `MSC_A_IP1)    ? {17'h0, ip1} :
		(paddr == `MSC_A_DP2)    ? ext32(dp2) :
		(paddr == `MSC_A_IP2)    ? {17'h0, ip2} :
		(paddr == `MSC_A_OFFSET) ? ext32(offset) :
		(paddr == `MSC_A_DELAY)  ? {2'h0, minDly, 2'h0, maxDly} :
		(paddr == `MSC_A_SVC)    ? {16'h0, VERSION, 2'h0, calRange, svc} :
		(paddr == `MSC_A_VALUE)  ? ext32(dispVal) :
		(paddr == `MSC_A_MAX)    ? ext32(maxQ) :
		(paddr == `MSC_A_MIN)    ? ext32(minQ) :
		(paddr == `MSC_A_LIVE)   ? {17'h0, rawIn} : 32'h0;

	// Answer registered in setup so prdata comes from a flop
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= setupCyc;
			pslverr <= setupCyc & ~mapped;
			prdata  <= (setupCyc & mapped & ~pwrite) ? rdMux : 32'h0;
		end
	end

	// ==========================================
	// Front panel and user input events
	wire panelFree = svc inside {msc_pkg::SV_PROMPT, msc_pkg::SV_RESTORE,
		msc_pkg::SV_VERSION};
	wire uEdge     = rise[2];
	wire selPress  = rise[0] & panelFree & ctrl[`MSC_F_SELEN];
	wire rstPress  = rise[1] & panelFree & ctrl[`MSC_F_RSTEN];
	wire doReset   = (uEdge && ufunc == msc_pkg::UF_RESET) | rstPress | prstPend;
	wire zeroNow   = (uEdge && ufunc == msc_pkg::UF_ZERO)
		| (doReset & zeroRst & asg[0] & (shownSel == 2'h0));
	wire maxLoad   = doReset & asg[1];
	wire minLoad   = doReset & asg[2];
	wire levelUp   = uEdge && ufunc == msc_pkg::UF_LEVEL && BACKLIT;
	wire colorFlip = uEdge && ufunc == msc_pkg::UF_COLOR && BACKLIT;
	wire printNow  = uEdge && ufunc inside {msc_pkg::UF_PRINT, msc_pkg::UF_PRST};
	wire frozen    = lvl[2] && ufunc == msc_pkg::UF_HOLD && asg[shownSel];
	wire scrollStep = secTick & scrollOn
		& (scrollSecs == 3'(`MSC_SCROLL_S - 1));
	wire advance   = selPress | (uEdge && ufunc == msc_pkg::UF_DSEL)
		| scrollStep;
	wire [1:0] nextShown = (shownSel == 2'h0 && maxEn) ? 2'h1 :
		(shownSel != 2'h2 && minEn) ? 2'h2 : 2'h0;
	wire [2:0] nextLevel = (curLevel >= `MSC_LVL_MAX) ? `MSC_LVL_MIN
		: curLevel + 3'h1;

	// ==========================================
	// Control register; hardware steps win over a same-cycle write
	always_ff @(posedge clk) begin
		if (sys_rst || restoreNow) begin
			ctrl <= `MSC_CTRL_RST;
		end else begin
			if (wrCtrl)
				ctrl <= pwdata;
			if (levelUp)
				ctrl[`MSC_F_LEVEL +: 3] <= nextLevel;
			if (colorFlip)
				ctrl[`MSC_F_COLOR] <= ~ctrl[`MSC_F_COLOR];
		end
	end
	assign intensity   = curLevel;
	assign colourGreen = ctrl[`MSC_F_COLOR];

	// Scaling points; values clipped into their legal spans
	always_ff @(posedge clk) begin
		if (sys_rst || restoreNow) begin
			dp1 <= 18'sh0;
			ip1 <= 15'h0;
			dp2 <= `MSC_DP2_RST;
			ip2 <= `MSC_IP2_RST;
		end else if (wrCmd && measured) begin
			if (pwdata[0])
				ip1 <= clampI({17'h0, rawIn});
			if (pwdata[1])
				ip2 <= clampI({17'h0, rawIn});
		end else if (wrPts) begin
			if (paddr == `MSC_A_DP1)
				dp1 <= clampD(35'(signed'(pwdata)));
			if (paddr == `MSC_A_DP2)
				dp2 <= clampD(35'(signed'(pwdata)));
			if (paddr == `MSC_A_IP1)
				ip1 <= clampI(pwdata);
			if (paddr == `MSC_A_IP2)
				ip2 <= clampI(pwdata);
		end
	end

	// Offset; zeroing overrides a write in the same cycle
	always_ff @(posedge clk) begin
		if (sys_rst || restoreNow)
			offset <= 18'sh0;
		else if (zeroNow)
			offset <= -scaledQ;
		else if (wrOff)
			offset <= pwdata[17:0];
	end

	// Capture delays in seconds
	always_ff @(posedge clk) begin
		if (sys_rst || restoreNow) begin
			maxDly <= 14'h0;
			minDly <= 14'h0;
		end else if (wrDly) begin
			maxDly <= clampS(pwdata[15:0]);
			minDly <= clampS(pwdata[`MSC_F_MINDLY +: 16]);
		end
	end

	// ==========================================
	// Two-point line; same formula inside and outside the points
	wire signed [15:0] inDiff = $signed({1'b0, rawIn}) - $signed({1'b0, ip1});
	wire signed [15:0] inSpan = $signed({1'b0, ip2}) - $signed({1'b0, ip1});
	wire signed [18:0] dSpan  = {dp2[17], dp2} - {dp1[17], dp1};
	wire signed [34:0] prod   = inDiff * dSpan;
	wire signed [34:0] quot   = (inSpan == 16'sh0) ? 35'sh0
		: prod / inSpan;
	wire signed [34:0] lineV  = quot + 35'(dp1);
	assign dispVal = clampD(35'(scaledQ) + 35'(offset));

	// Pipeline the divider result to keep the path short
	always_ff @(posedge clk) begin
		if (sys_rst)
			scaledQ <= 18'sh0;
		else
			scaledQ <= clampD(lineV);
	end

	// ==========================================
	// Min and max capture units
	msc_cap_if maxIf ();
	msc_cap_if minIf ();
	assign maxIf.disp = dispVal;
	assign maxIf.en   = maxEn;
	assign maxIf.dly  = maxDly;
	assign maxIf.tick = secTick;
	assign maxIf.load = maxLoad;
	assign minIf.disp = dispVal;
	assign minIf.en   = minEn;
	assign minIf.dly  = minDly;
	assign minIf.tick = secTick;
	assign minIf.load = minLoad;
	assign maxQ       = maxIf.val;
	assign minQ       = minIf.val;

	msc_capture #(
		.IS_MAX(1'b1)
	) u_max (
		.clk    (clk),
		.sys_rst(sys_rst),
		.cif    (maxIf.cap)
	);

	msc_capture #(
		.IS_MAX(1'b0)
	) u_min (
		.clk    (clk),
		.sys_rst(sys_rst),
		.cif    (minIf.cap)
	);

	// ==========================================
	// One-second tick and scroll count
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			divCnt  <= '0;
			secTick <= 1'b0;
		end else begin
			secTick <= divCnt == DW'(SEC_CYCLES - 1);
			divCnt  <= (divCnt == DW'(SEC_CYCLES - 1)) ? '0 : divCnt + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || !scrollOn)
			scrollSecs <= 3'h0;
		else if (scrollStep)
			scrollSecs <= 3'h0;
		else if (secTick)
			scrollSecs <= scrollSecs + 3'h1;
	end

	// ==========================================
	// Shown display, held output and one-cycle events
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			shownSel <= 2'h0;
			dispOut  <= 18'h0;
			printReq <= 1'b0;
			prstPend <= 1'b0;
			spReset  <= 2'h0;
		end else begin
			if (advance)
				shownSel <= nextShown;
			if (!frozen)
				dispOut <= (shownSel == 2'h1) ? maxQ
					: (shownSel == 2'h2) ? minQ : dispVal;
			printReq <= printNow;
			prstPend <= uEdge && ufunc == msc_pkg::UF_PRST;
			spReset  <= {uEdge && ufunc inside {msc_pkg::UF_SP2, msc_pkg::UF_SPBOTH},
				uEdge && ufunc inside {msc_pkg::UF_SP1, msc_pkg::UF_SPBOTH}};
		end
	end

	// ==========================================
	// Service codes and calibration sequence
	always_comb begin
		next_svc = svc;
		unique case (svc)
			msc_pkg::SV_PROMPT:
				if (svcWr && svcCode == `MSC_SVC_RESTORE)
					next_svc = msc_pkg::SV_RESTORE;
				else if (svcWr && svcCode == `MSC_SVC_VERSION)
					next_svc = msc_pkg::SV_VERSION;
				else if (svcWr && svcCode == `MSC_SVC_CAL)
					next_svc = msc_pkg::SV_ARMED;
			msc_pkg::SV_RESTORE,
			msc_pkg::SV_VERSION:
				if (svcSecs >= 4'(`MSC_IND_S))
					next_svc = msc_pkg::SV_PROMPT;
			msc_pkg::SV_ARMED:
				if (svcWr)
					next_svc = msc_pkg::SV_PROMPT;
				else if (lvl[0] && svcSecs >= 4'(`MSC_CALHOLD_S))
					next_svc = msc_pkg::SV_CALSEL;
			msc_pkg::SV_CALSEL:
				if (rise[0])
					next_svc = (calRange == `MSC_RANGE_EXIT) ? msc_pkg::SV_PROMPT
						: msc_pkg::SV_CALZERO;
			msc_pkg::SV_CALZERO:
				if (rise[0])
					next_svc = msc_pkg::SV_CALRUN;
			msc_pkg::SV_CALRUN:
				if (svcSecs >= 4'(`MSC_CALZERO_S))
					next_svc = msc_pkg::SV_CALFULL;
			msc_pkg::SV_CALFULL:
				if (rise[0])
					next_svc = msc_pkg::SV_CALSEL;
		endcase
	end

	// Seconds in state; armed count restarts when select lets go
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			svc      <= msc_pkg::SV_PROMPT;
			svcSecs  <= 4'h0;
			calRange <= 3'h0;
			calZero  <= 1'b0;
			calFull  <= 1'b0;
		end else begin
			svc     <= next_svc;
			calZero <= next_svc == msc_pkg::SV_CALRUN;
			calFull <= next_svc == msc_pkg::SV_CALFULL;
			if (next_svc != svc || (svc == msc_pkg::SV_ARMED && !lvl[0]))
				svcSecs <= 4'h0;
			else if (secTick && svcSecs != 4'hf)
				svcSecs <= svcSecs + 4'h1;
			if (svc == msc_pkg::SV_CALSEL && rise[1])
				calRange <= (calRange == `MSC_RANGE_EXIT) ? 3'h0
					: calRange + 3'h1;
		end
	end

	// ==========================================
	// Checks
	a_zero_offset:
	assert property (@(posedge clk) disable iff (sys_rst)
		(uEdge && ufunc == msc_pkg::UF_ZERO && !restoreNow) |=> offset == -$past(scaledQ))
	else $error("zero edge did not cancel the reading");

	a_zero_gate:
	assert property (@(posedge clk) disable iff (sys_rst)
		(rstPress && shownSel != 2'h0 && !uEdge && !apbWr && !prstPend)
			|=> $stable(offset))
	else $error("zero on reset while input not shown");

	a_hold_freeze:
	assert property (@(posedge clk) disable iff (sys_rst)
		frozen |=> $stable(dispOut))
	else $error("held display changed");

	a_level_step:
	assert property (@(posedge clk) disable iff (sys_rst)
		(levelUp && !restoreNow) |=> intensity == (($past(intensity) >= 3'h5) ? 3'h1
			: $past(intensity) + 3'h1))
	else $error("brightness did not step one level");

	a_print_reset:
	assert property (@(posedge clk) disable iff (sys_rst)
		(uEdge && ufunc == msc_pkg::UF_PRST) |=> printReq && prstPend
			&& (maxLoad == asg[1]))
	else $error("print and reset sequence wrong");

	a_restore_ctrl:
	assert property (@(posedge clk) disable iff (sys_rst)
		restoreNow |=> ctrl == `MSC_CTRL_RST && svc == msc_pkg::SV_RESTORE)
	else $error("restore code did not reload defaults");

	a_version_back:
	assert property (@(posedge clk) disable iff (sys_rst)
		(svc == msc_pkg::SV_VERSION && svcSecs >= 4'h2) |=> svc == msc_pkg::SV_PROMPT)
	else $error("version display did not return to prompt");

	a_cal_zero_len:
	assert property (@(posedge clk) disable iff (sys_rst)
		(svc == msc_pkg::SV_CALRUN && svcSecs >= 4'h8) |=> calFull && !calZero)
	else $error("zero step did not end after eight seconds");
endmodule

// File: testbench/msc_panel_model.sv
`timescale 1ns/100ps
// ==========================================
// Front panel: select button, reset button, user input line
module msc_panel_model (
	input  wire logic clk,
	output logic      selBtnPin,
	output logic      rstBtnPin,
	output logic      userPin
);
	// Released buttons and an idle user line sit low
	initial begin
		selBtnPin = 1'b0;
		rstBtnPin = 1'b0;
		userPin = 1'b0;
	end
	// Change one line just after an edge; 0 select, 1 reset, 2 user
	task automatic drive(input int which, input logic v);
		@(posedge clk);
		case (which)
			0: selBtnPin <= v;
			1: rstBtnPin <= v;
			default: userPin <= v;
		endcase
	endtask
	// Gap after release lets the pin synchroniser settle
	task automatic press(input int which, input int cycles);
		drive(which, 1'b1);
		repeat (cycles) @(posedge clk);
		drive(which, 1'b0);
		repeat (8) @(posedge clk);
	endtask
endmodule

// File: testbench/tb_meter_scaling_capture.sv
`timescale 1ns/100ps
`include "msc_consts.svh"
module tb_meter_scaling_capture;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        selBtnPin;
	logic        rstBtnPin;
	logic        userPin;
	logic [14:0] rawIn = 15'h0;
	logic [17:0] dispOut;
	logic [1:0]  shownSel;
	logic [2:0]  intensity;
	logic        colourGreen;
	logic        printReq;
	logic [1:0]  spReset;
	logic [2:0]  calRange;
	logic        calZero;
	logic        calFull;
	logic [31:0] rd;
	logic        seenPrint = 1'b0;
	logic [1:0]  seenSp = 2'h0;
	int          err_total = 0;
	int          total_checks = 0;
	localparam logic [31:0] BASE = `MSC_CTRL_RST;
	// Zero with reset, assignment on the input display
	localparam logic [31:0] ZR   = (32'h1 << 11) | (32'h1 << 5);

	// Twenty-cycle second keeps every timed step under two hundred cycles
	msc_meter_core #(.SEC_CYCLES(20)) i_dut (.clk(clk), .sys_rst(sys_rst), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .selBtnPin(selBtnPin), .rstBtnPin(rstBtnPin),
		.userPin(userPin), .rawIn(rawIn), .dispOut(dispOut), .shownSel(shownSel),
		.intensity(intensity), .colourGreen(colourGreen), .printReq(printReq),
		.spReset(spReset), .calRange(calRange), .calZero(calZero), .calFull(calFull));
	msc_panel_model i_panel (.clk(clk), .selBtnPin(selBtnPin), .rstBtnPin(rstBtnPin),
		.userPin(userPin));

	// ==========================================
	// Clock, pulse catchers, watchdog
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		if (printReq === 1'b1)
			seenPrint <= 1'b1;
		// Only on a pulse, so a clear by the scenario is never undone
		if (spReset != 2'h0)
			seenSp <= seenSp | spReset;
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		report_and_stop();
	end

	// ==========================================
	// Bus cycle and comparison helpers
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// No cycle count assumed; only the watchdog ends a hung wait
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	function automatic logic [31:0] sx(input logic [17:0] v);
		return {{14{v[17]}}, v};
	endfunction
	task automatic settle();
		repeat (8) @(posedge clk);
	endtask

	// ==========================================
	// Scenarios
	task automatic t_scale();
		apb(1, `MSC_A_DP1, 32'd100000);
		apb(0, `MSC_A_DP1, 0);
		chk("dp1 clamp", sx(`MSC_DISP_MAX), sx(rd[17:0]));
		apb(1, `MSC_A_IP1, 32'd30000);
		apb(0, `MSC_A_IP1, 0);
		chk("ip1 clamp", 32'(`MSC_IN_MAX), 32'(rd[14:0]));
		apb(1, `MSC_A_DP1, 32'd100);
		apb(1, `MSC_A_IP1, 32'd1000);
		apb(1, `MSC_A_DP2, 32'd1100);
		apb(1, `MSC_A_IP2, 32'd2000);
		rawIn <= 15'd3000;
		settle();
		chk("above span", sx(18'd2100), sx(dispOut));
		rawIn <= 15'd500;
		settle();
		chk("below span", sx(-18'sd400), sx(dispOut));
		apb(1, 8'h34, 32'h1);
		chk("unmapped err", 32'h1, 32'(pslverr));
		$display("test scale done");
	endtask
	task automatic t_zero();
		rawIn <= 15'd3000;
		apb(1, `MSC_A_CTRL, BASE | (32'd2 << 1));
		i_panel.press(2, 3);
		chk("zeroed", 32'h0, sx(dispOut));
		apb(0, `MSC_A_OFFSET, 0);
		chk("offset", sx(-18'sd2100), sx(rd[17:0]));
		apb(1, `MSC_A_OFFSET, 32'h0);
		apb(1, `MSC_A_CTRL, BASE | ZR);
		i_panel.press(1, 3);
		apb(0, `MSC_A_OFFSET, 0);
		chk("zero on reset", sx(-18'sd2100), sx(rd[17:0]));
		apb(1, `MSC_A_OFFSET, 32'h0);
		$display("test zero done");
	endtask
	task automatic t_measured();
		rawIn <= 15'd1234;
		apb(1, `MSC_A_CTRL, BASE | 32'h1);
		apb(1, `MSC_A_CMD, 32'h1);
		apb(0, `MSC_A_IP1, 0);
		chk("stored ip1", 32'd1234, 32'(rd[14:0]));
		apb(1, `MSC_A_CTRL, BASE);
		apb(1, `MSC_A_CMD, 32'h2);
		apb(0, `MSC_A_IP2, 0);
		chk("keyed ip2", 32'd2000, 32'(rd[14:0]));
		apb(1, `MSC_A_IP1, 32'd1000);
		$display("test measured done");
	endtask
	task automatic t_functions();
		logic [3:0] fn [5] = '{4'd8, 4'd9, 4'd10, 4'd11, 4'd12};
		logic [1:0] sp [5] = '{2'd0, 2'd0, 2'd1, 2'd2, 2'd3};
		apb(1, `MSC_A_CTRL, BASE | (32'd6 << 1));
		i_panel.press(2, 3);
		chk("level wrap", 32'd1, 32'(intensity));
		i_panel.press(2, 3);
		chk("level up", 32'd2, 32'(intensity));
		apb(1, `MSC_A_CTRL, BASE | (32'd7 << 1));
		i_panel.press(2, 3);
		chk("colour", 32'h1, 32'(colourGreen));
		for (int i = 0; i < 5; i++) begin
			apb(1, `MSC_A_CTRL, BASE | (32'(fn[i]) << 1));
			seenPrint = 1'b0;
			seenSp = 2'h0;
			i_panel.press(2, 3);
			chk("print", 32'(i < 2), 32'(seenPrint));
			chk("setpoint", 32'(sp[i]), 32'(seenSp));
		end
		$display("test functions done");
	endtask
	task automatic t_hold();
		rawIn <= 15'd3000;
		apb(1, `MSC_A_CTRL, BASE | (32'd4 << 1) | (32'h1 << 5));
		settle();
		i_panel.drive(2, 1'b1);
		settle();
		rawIn <= 15'd500;
		settle();
		chk("held", sx(18'd2100), sx(dispOut));
		i_panel.drive(2, 1'b0);
		settle();
		chk("released", sx(-18'sd400), sx(dispOut));
		$display("test hold done");
	endtask
	task automatic t_capture();
		rawIn <= 15'd3000;
		apb(1, `MSC_A_DELAY, 32'd2);
		apb(1, `MSC_A_CTRL, BASE | (32'h1 << 8));
		apb(0, `MSC_A_MAX, 0);
		chk("max early", sx(`MSC_DISP_MIN), sx(rd[17:0]));
		repeat (120) @(posedge clk);
		apb(0, `MSC_A_MAX, 0);
		chk("max late", sx(18'd2100), sx(rd[17:0]));
		rawIn <= 15'd1500;
		apb(1, `MSC_A_CTRL, BASE | (32'h1 << 8) | (32'd3 << 1) | (32'h1 << 6));
		i_panel.press(2, 3);
		apb(0, `MSC_A_MAX, 0);
		chk("max reset", sx(18'd600), sx(rd[17:0]));
		apb(1, `MSC_A_CTRL, BASE | (32'h3 << 8) | ZR);
		i_panel.press(0, 3);
		chk("advance", 32'd1, 32'(shownSel));
		apb(0, `MSC_A_MIN, 0);
		chk("min zero delay", sx(18'd600), sx(rd[17:0]));
		i_panel.press(1, 3);
		apb(0, `MSC_A_OFFSET, 0);
		chk("no zero off input", 32'h0, rd);
		apb(1, `MSC_A_CTRL, BASE | (32'h3 << 8) | ZR | (32'h1 << 10));
		repeat (100) @(posedge clk);
		chk("scroll", 32'd2, 32'(shownSel));
		$display("test capture done");
	endtask
	task automatic t_service();
		apb(1, `MSC_A_SVC, 32'd50);
		apb(0, `MSC_A_SVC, 0);
		chk("version state", 32'd2, 32'(rd[2:0]));
		chk("version", 32'(`MSC_VERSION), 32'(rd[15:8]));
		repeat (60) @(posedge clk);
		apb(0, `MSC_A_SVC, 0);
		chk("prompt", 32'd0, 32'(rd[2:0]));
		apb(1, `MSC_A_CTRL, BASE | 32'h1);
		apb(1, `MSC_A_SVC, 32'd66);
		apb(0, `MSC_A_SVC, 0);
		chk("restore state", 32'd1, 32'(rd[2:0]));
		apb(0, `MSC_A_CTRL, 0);
		chk("defaults", BASE, rd);
		repeat (60) @(posedge clk);
		apb(1, `MSC_A_SVC, 32'd48);
		i_panel.press(0, 60);
		apb(0, `MSC_A_SVC, 0);
		chk("cal select", 32'd4, 32'(rd[2:0]));
		i_panel.press(1, 3);
		chk("cal range", 32'd1, 32'(calRange));
		i_panel.press(0, 3);
		i_panel.press(0, 3);
		chk("cal zero step", 32'h1, 32'(calZero));
		repeat (200) @(posedge clk);
		chk("cal full step", 32'h2, 32'({calFull, calZero}));
		$display("test service done");
	endtask

	// ==========================================
	// Verdict and main sequence
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		chk("intensity rst", 32'd5, 32'(intensity));
		apb(0, `MSC_A_CTRL, 0);
		chk("ctrl rst", BASE, rd);
		t_scale();
		t_zero();
		t_measured();
		t_functions();
		t_hold();
		t_capture();
		t_service();
		report_and_stop();
	end
endmodule
